// ===== core/acrf_top.sv
`default_nettype none

// Converter clock control and result placement, reached over APB.
module acrf_top
	import acrf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ACRF_AW-1:0] paddr,
	input wire logic [ACRF_DW-1:0] pwdata,
	output logic [ACRF_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic crystal_reference_clock,
	input wire logic raw_valid,
	input wire logic [ACRF_RAW_W-1:0] raw_result,
	output logic converter_clock_enable,
	output acrf_ctrl_t ctrl,
	output acrf_result_t result,
	output logic result_ready
);

	// Previous sample of the crystal input, for rising edge detection.
	logic crystal_prev;
	// One pulse per chosen source clock period.
	logic source_tick;
	// Access phase that completes at this edge.
	logic access_done;
	// Address decode hits.
	logic hit_ctrl;
	logic hit_result;
	// Read data and error for the pending answer.
	logic [ACRF_DW-1:0] next_prdata;
	logic next_pslverr;

	// The access completes on the edge that sees pready high.
	assign access_done = psel && penable && pready;

	// Address decode of the two words.
	always_comb begin
		hit_ctrl = 1'b0;
		hit_result = 1'b0;
		if (paddr == ACRF_CTRL_ADDR) begin
			hit_ctrl = 1'b1;
		end else if (paddr == ACRF_RESULT_ADDR) begin
			hit_result = 1'b1;
		end
	end

	// Read data chosen from the decode; unmapped reads give zero.
	always_comb begin
		next_prdata = '0;
		next_pslverr = 1'b0;
		if (hit_ctrl) begin
			// Fields sit in bits 7..2; bits 1..0 keep their zero default.
			next_prdata[7:ACRF_JUSTIFY_LSB] = ctrl;
		end else if (hit_result) begin
			next_prdata[15:0] = result;
		end else begin
			next_prdata = '0;
			next_pslverr = 1'b1;
		end
	end

	// APB answer: one wait state, then pready for a single cycle.
	// The wait state lets the read data come from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			prdata <= pwrite ? '0 : next_prdata;
			pslverr <= next_pslverr;
		end else begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end
	end

	// Control register, written at the completing edge only.
	// crystal source at reset, right-justified at reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= acrf_ctrl_t'(ACRF_CTRL_RESET[7:ACRF_JUSTIFY_LSB]);
		end else if (access_done && pwrite && hit_ctrl) begin
			ctrl <= acrf_ctrl_t'(pwdata[7:ACRF_JUSTIFY_LSB]
				& ACRF_CTRL_WMASK[7:ACRF_JUSTIFY_LSB]);
		end
	end

	// Crystal input is taken as synchronous; keep last level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crystal_prev <= 1'b0;
		end else begin
			crystal_prev <= crystal_reference_clock;
		end
	end

	// pick bus clock or crystal edges as the input.
	// The crystal must run well below pclk for every edge to be seen.
	always_comb begin
		if (ctrl.converter_source_select == ACRF_SRC_BUS) begin
			source_tick = 1'b1;
		end else begin
			source_tick = crystal_reference_clock && !crystal_prev;
		end
	end

	// Divider turning source ticks into the converter enable.
	acrf_prescaler acrf_prescaler_i (
		.pclk(pclk),
		.presetn(presetn),
		.source_tick(source_tick),
		.ctrl(ctrl),
		.converter_clock_enable(converter_clock_enable)
	);

	// results placed by the current justify field.
	acrf_formatter acrf_formatter_i (
		.pclk(pclk),
		.presetn(presetn),
		.raw_valid(raw_valid),
		.raw_result(raw_result),
		.justify(ctrl.justify),
		.result(result),
		.result_ready(result_ready)
	);

endmodule // acrf_top

`default_nettype wire

// ===== core/acrf_pkg.sv
// Behaviour
// - Codes 000..011 divide by 1, 2, 4, 8.
// - Prescale top bit set divides by sixteen.
// - Source bit 1 bus clock, 0 crystal.
// - Reset selects the crystal reference clock.
// - Justify codes: truncate, right, left, signed.
// - Reset loads right-justified placement code 01.
// - Results laid out per current justify field.
`default_nettype none

package acrf_pkg;

	// Clock rate of pclk in hertz, and the target converter rate.
	localparam int unsigned ACRF_PCLK_HZ = 20000000;
	localparam int unsigned ACRF_TARGET_HZ = 1000000;

	// Bus widths of the register slave.
	localparam int ACRF_AW = 12;
	localparam int ACRF_DW = 32;

	// Printed register offset is an index; the byte address is four times it.
	localparam logic [ACRF_AW-1:0] ACRF_CTRL_INDEX = 12'h03F;
	localparam logic [ACRF_AW-1:0] ACRF_CTRL_ADDR = 12'h0FC;
	// Result register placed just above the control register.
	localparam logic [ACRF_AW-1:0] ACRF_RESULT_INDEX = 12'h040;
	localparam logic [ACRF_AW-1:0] ACRF_RESULT_ADDR = 12'h100;

	// Control register field positions.
	localparam int ACRF_PRESCALE_LSB = 5;
	localparam int ACRF_SOURCE_BIT = 4;
	localparam int ACRF_JUSTIFY_LSB = 2;

	// Control register reset value: crystal source, divide by 1, right.
	localparam logic [7:0] ACRF_CTRL_RESET = 8'h04;
	// Bits of the control byte that software can write.
	localparam logic [7:0] ACRF_CTRL_WMASK = 8'hFC;

	// Prescale codes.
	localparam logic [2:0] ACRF_DIV1 = 3'h0;
	localparam logic [2:0] ACRF_DIV2 = 3'h1;
	localparam logic [2:0] ACRF_DIV4 = 3'h2;
	localparam logic [2:0] ACRF_DIV8 = 3'h3;

	// Terminal counts for each divide ratio (ratio minus one).
	localparam logic [3:0] ACRF_LIM1 = 4'h0;
	localparam logic [3:0] ACRF_LIM2 = 4'h1;
	localparam logic [3:0] ACRF_LIM4 = 4'h3;
	localparam logic [3:0] ACRF_LIM8 = 4'h7;
	localparam logic [3:0] ACRF_LIM16 = 4'hF;

	// Source select values.
	localparam logic ACRF_SRC_CRYSTAL = 1'b0;
	localparam logic ACRF_SRC_BUS = 1'b1;

	// Result placement modes.
	typedef enum logic [1:0] {
		ACRF_TRUNC8 = 2'h0,
		ACRF_RIGHT = 2'h1,
		ACRF_LEFT = 2'h2,
		ACRF_LEFT_SIGNED = 2'h3
	} acrf_justify_t;

	// Width of a raw conversion and position of its sign bit.
	localparam int ACRF_RAW_W = 10;
	localparam int ACRF_RAW_MSB = 9;

	// Decoded contents of the control register.
	typedef struct packed {
		logic [2:0] converter_prescale_select;
		logic converter_source_select;
		acrf_justify_t justify;
	} acrf_ctrl_t;

	// Placed result as the two result bytes.
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} acrf_result_t;

endpackage

`default_nettype wire

// ===== core/acrf_prescaler.sv
`default_nettype none

// Counts source ticks and gives one enable pulse per divided period.
module acrf_prescaler
	import acrf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic source_tick,
	input wire acrf_ctrl_t ctrl,
	output logic converter_clock_enable
);

	// Tick counter within one divided period.
	logic [3:0] count;
	// Settings seen last cycle, to spot a change.
	logic [3:0] last_setting;
	// Terminal count for the current ratio.
	logic [3:0] limit;
	// High for one cycle when the ratio or source moves.
	logic restart;

	// divide ratio decode, top bit forces sixteen.
	always_comb begin
		if (ctrl.converter_prescale_select[2]) begin
			limit = ACRF_LIM16;
		end else if (ctrl.converter_prescale_select == ACRF_DIV1) begin
			limit = ACRF_LIM1;
		end else if (ctrl.converter_prescale_select == ACRF_DIV2) begin
			limit = ACRF_LIM2;
		end else if (ctrl.converter_prescale_select == ACRF_DIV4) begin
			limit = ACRF_LIM4;
		end else begin
			limit = ACRF_LIM8;
		end
	end

	assign restart = last_setting !=
		{ctrl.converter_prescale_select, ctrl.converter_source_select};

	// Remember the settings so that a change is seen.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_setting <= 4'h0;
		end else begin
			last_setting <= {ctrl.converter_prescale_select,
				ctrl.converter_source_select};
		end
	end

	// restart count on change, pulse at the limit.
	// A restart drops the pending pulse so no short period leaks out.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 4'h0;
			converter_clock_enable <= 1'b0;
		end else if (restart) begin
			count <= 4'h0;
			converter_clock_enable <= 1'b0;
		end else if (source_tick) begin
			converter_clock_enable <= (count == limit);
			count <= (count == limit) ? 4'h0 : count + 4'h1;
		end else begin
			converter_clock_enable <= 1'b0;
		end
	end

endmodule // acrf_prescaler

`default_nettype wire

// ===== core/acrf_formatter.sv
`default_nettype none

// Places a raw conversion into the two result bytes.
module acrf_formatter
	import acrf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic raw_valid,
	input wire logic [ACRF_RAW_W-1:0] raw_result,
	input wire acrf_justify_t justify,
	output acrf_result_t result,
	output logic result_ready
);

	// Combinational placement of the incoming sample.
	acrf_result_t next_result;

	always_comb begin
		next_result = '0;
		case (justify)
			ACRF_TRUNC8: begin
				// Only the eight most significant bits are kept.
				next_result.low = raw_result[ACRF_RAW_MSB -: 8];
			end
			ACRF_RIGHT: begin
				next_result.high = {6'h00, raw_result[ACRF_RAW_MSB -: 2]};
				next_result.low = raw_result[7:0];
			end
			ACRF_LEFT: begin
				next_result.high = raw_result[ACRF_RAW_MSB -: 8];
				next_result.low = {raw_result[1:0], 6'h00};
			end
			default: begin
				// Signed: offset binary turned to two's complement.
				next_result.high = {~raw_result[ACRF_RAW_MSB],
					raw_result[ACRF_RAW_MSB-1 -: 7]};
				next_result.low = {raw_result[1:0], 6'h00};
			end
		endcase
	end

	// capture using the mode in force at the sample.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= '0;
			result_ready <= 1'b0;
		end else begin
			result_ready <= raw_valid;
			if (raw_valid) begin
				result <= next_result;
			end
		end
	end

endmodule // acrf_formatter

`default_nettype wire

// ===== dv/acrf_core_model.sv
`default_nettype none
// Conversion core: a free crystal and one result per request.
module acrf_core_model
	import acrf_pkg::*;
#(parameter int XHALF = 3)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic converter_clock_enable,
	input wire logic go,
	input wire logic [ACRF_RAW_W-1:0] value,
	output logic crystal_reference_clock,
	output logic raw_valid,
	output logic [ACRF_RAW_W-1:0] raw_result
);
	int xcnt;
	logic pend;
	// Results launch only on a converter clock pulse.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xcnt <= 0;
			crystal_reference_clock <= 1'b0;
			pend <= 1'b0;
			raw_valid <= 1'b0;
			raw_result <= 10'h000;
		end else begin
			xcnt <= (xcnt == XHALF - 1) ? 0 : xcnt + 1;
			if (xcnt == XHALF - 1)
				crystal_reference_clock <= !crystal_reference_clock;
			raw_valid <= pend && converter_clock_enable;
			// Data flips between results, so stale data never looks valid.
			raw_result <= (pend && converter_clock_enable) ? value : ~raw_result;
			pend <= go || (pend && !converter_clock_enable);
		end
	end
endmodule // acrf_core_model
`default_nettype wire

// ===== dv/acrf_top_monitor.sv
`default_nettype none
// Checks decode and placement at the top ports.
module acrf_top_monitor
	import acrf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [ACRF_AW-1:0] paddr,
	input wire logic [ACRF_DW-1:0] pwdata,
	input wire logic raw_valid,
	input wire logic [ACRF_RAW_W-1:0] raw_result,
	input wire logic converter_clock_enable,
	input wire acrf_ctrl_t ctrl,
	input wire acrf_result_t result,
	input wire logic result_ready
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_wr;
		psel && penable && pwrite && pready && paddr == ACRF_CTRL_ADDR;
	endsequence
	// Bus source at divide by one, settled for three cycles.
	sequence s_div1;
		(ctrl[5:2] == 4'h1) [*3];
	endsequence
	AST_WRITE: assert property (s_wr |=> ctrl == $past(pwdata[7:2]))
		else $error("control write lost");
	AST_RESET: assert property ($rose(presetn) |-> ctrl == 6'h01)
		else $error("control reset value wrong");
	AST_DIV1: assert property (s_div1 |=> converter_clock_enable)
		else $error("missing divide by one pulse");
	AST_RESTART: assert property (
		$changed(ctrl[5:2]) |=> !converter_clock_enable)
		else $error("pulse right after a divide change");
	AST_PULSE: assert property (
		converter_clock_enable && ctrl[5:3] != 3'h0 |=> !converter_clock_enable)
		else $error("pulse wider than one cycle");
	AST_READY: assert property (result_ready == $past(raw_valid))
		else $error("result ready out of step");
	AST_RIGHT: assert property (
		raw_valid && ctrl.justify == ACRF_RIGHT
		|=> result == {6'h00, $past(raw_result)})
		else $error("right placement wrong");
	AST_SIGNED: assert property (
		raw_valid && ctrl.justify == ACRF_LEFT_SIGNED
		|=> result.high[7] != $past(raw_result[9]))
		else $error("signed top bit not inverted");
endmodule // acrf_top_monitor
bind acrf_top acrf_top_monitor acrf_top_monitor_i (.pclk, .presetn, .psel,
	.penable, .pwrite, .pready, .paddr, .pwdata, .raw_valid, .raw_result,
	.converter_clock_enable, .ctrl, .result, .result_ready);
`default_nettype wire

// ===== dv/adc_clock_and_result_format_test.sv
`default_nettype none
`define CHK(w, x, g) begin \
	n_compared++; \
	if ((g) !== (x)) begin \
		err_total++; \
		$display("unexpected %s exp %0h got %0h", w, x, g); \
	end \
end
module adc_clock_and_result_format_test
	import acrf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int XHALF = 3;
	int err_total, n_compared;
	logic pclk, presetn, psel, penable, pwrite, go, pready, pslverr, xclk, en;
	logic raw_valid, result_ready;
	logic [ACRF_AW-1:0] paddr;
	logic [ACRF_DW-1:0] pwdata, prdata;
	logic [ACRF_RAW_W-1:0] value, raw_result;
	acrf_ctrl_t ctrl;
	acrf_result_t result;
	acrf_top acrf_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .crystal_reference_clock(xclk),
		.raw_valid, .raw_result, .converter_clock_enable(en), .ctrl,
		.result, .result_ready);
	acrf_core_model #(.XHALF(XHALF)) acrf_core_model_i (.pclk, .presetn,
		.converter_clock_enable(en), .go, .value,
		.crystal_reference_clock(xclk), .raw_valid, .raw_result);
	function automatic logic [15:0] place(logic [1:0] j, logic [9:0] r);
		case (j)
			2'h0: return {8'h00, r[9:2]};
			2'h1: return {6'h00, r};
			2'h2: return {r, 6'h00};
			default: return {~r[9], r[8:0], 6'h00};
		endcase
	endfunction
	// Holds the request until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the watchdog ends a wait for the answer.
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] b);
		logic [31:0] q;
		logic e;
		apb(1'b1, ACRF_CTRL_ADDR, {24'h000000, b}, q, e);
	endtask
	// Cycles from one enable pulse to the next.
	task automatic gap(output int g);
		for (int n = 0; n < 200 && en !== 1'b1; n++)
			@(posedge pclk);
		@(posedge pclk);
		for (g = 1; g < 200 && en !== 1'b1; g++)
			@(posedge pclk);
	endtask
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		apb(1'b0, ACRF_CTRL_ADDR, 32'h00000000, q, e);
		`CHK("ctrl reset", 32'h00000004, q)
		`CHK("ctrl port", 6'h01, ctrl)
		apb(1'b1, ACRF_CTRL_ADDR, 32'hFFFFFFFF, q, e);
		apb(1'b0, ACRF_CTRL_ADDR, 32'h00000000, q, e);
		`CHK("ctrl bits", 32'h000000FC, q)
		apb(1'b0, 12'h200, 32'h00000000, q, e);
		`CHK("unmapped", 1'b1, e)
	endtask
	task automatic t_divide();
		int g;
		for (int c = 0; c < 8; c++) begin
			wr({c[2:0], 1'b1, 4'h4});
			// Skip pulses still launched under the old setting.
			repeat (2) @(posedge pclk);
			gap(g);
			gap(g);
			`CHK("bus ratio", c > 3 ? 16 : 1 << c, g)
		end
		wr(8'h24);
		repeat (2) @(posedge pclk);
		gap(g);
		gap(g);
		`CHK("crystal ratio", 4 * XHALF, g)
	endtask
	task automatic t_format();
		logic [31:0] q;
		logic e;
		for (int j = 0; j < 4; j++) begin
			// Bus clock over sixteen lands near the target rate.
			wr({4'h9, j[1:0], 2'h0});
			go <= 1'b1;
			@(posedge pclk);
			go <= 1'b0;
			for (int n = 0; n < 100 && result_ready !== 1'b1; n++)
				@(posedge pclk);
			`CHK("result", place(j[1:0], value), result)
			apb(1'b0, ACRF_RESULT_ADDR, 32'h00000000, q, e);
			`CHK("result word", {16'h0000, place(j[1:0], value)}, q)
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Whole run is under two thousand cycles.
	initial begin
		#200000;
		err_total++;
		print_verdict();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		go = 1'b0;
		value = 10'h2B5;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_divide();
		t_format();
		print_verdict();
	end
endmodule // adc_clock_and_result_format_test
`default_nettype wire
